// ===== common/smsc_pkg.sv
// Shared constants and types for the serial peripheral interface core
package smsc_pkg;
  localparam int SMSC_DW = 8;
  // Pin index of each synchronised serial input
  localparam int SMSC_PIN_MOSI = 0;
  localparam int SMSC_PIN_MISO = 1;
  localparam int SMSC_PIN_SCK  = 2;
  localparam int SMSC_PIN_SS   = 3;
  localparam int SMSC_PIN_N    = 4;
  // Sample counts that start one byte and the two that close it
  localparam logic [3:0] SMSC_CNT_ZERO  = 4'h0;
  localparam logic [3:0] SMSC_CNT_LAST  = 4'h7;
  localparam logic [3:0] SMSC_CNT_BYTE  = 4'h8;
  // Half period of the serial clock in core clocks, per divider select
  localparam logic [6:0] SMSC_HALF_TAB [4] = '{7'h02, 7'h08, 7'h20, 7'h40};
  localparam logic [6:0] SMSC_DIV_ZERO  = 7'h00;
  localparam logic [6:0] SMSC_DIV_ONE   = 7'h01;
  // Receive queue fill levels
  localparam logic [1:0] SMSC_RX_EMPTY  = 2'h0;
  localparam logic [1:0] SMSC_RX_ONE    = 2'h1;
  localparam logic [1:0] SMSC_RX_FULL   = 2'h2;
  // Reset values
  localparam logic [7:0] SMSC_BYTE_RST  = 8'h00;
  localparam logic       SMSC_MASTER_RST = 1'b0;
  typedef enum logic [1:0] {
    SMSC_ST_IDLE  = 2'b00,
    SMSC_ST_SHIFT = 2'b01
  } smsc_state_t;
endpackage

// ===== hdl/smsc_core.sv
// Byte-wide serial peripheral interface core, master or slave
`timescale 1ns/1ns
// Summary of operation
// - Eight-bit shifter, one out one in
// - Master selects slave low, then clocks
// - Data master-to-slave on MOSI, back on MISO
// - Data write loads shifter or transmit buffer
// - Data read returns first or second buffer
// - Slave clock synchronised, edges trigger shifting
// - Enabled core forces its input pins: MOSI, SCK, SS as slave, MISO as master
// - Slave MISO driven only while selected
// - Master write starts clock, eight bits, flag
// - Master select pin ignored when disabled or output
// - Select low as input drops master bit
// - Forced drop to slave sets done flag
// - Unbuffered early write sets collision, corrupts master shifter
// - Unbuffered byte to first buffer, overwritable
// - Unbuffered completion sets done flag, interrupt
// - Buffer enable bit; wait option master-inert
// - Buffered: master's first write sent, next held; slave's first write held
// - Buffered receive into two-entry queue
// - Both empty sets transfer-complete flag
// - Slave select high resets shift state
module smsc_core (
  input  wire logic       MCLK_I,
  input  wire logic       SRST_I,
  input  wire logic       ENABLE_I,
  input  wire logic       MASTER_WR_I,
  input  wire logic       MASTER_WDATA_I,
  output logic            MASTER_O,
  input  wire logic [1:0] CLOCK_DIVIDER_SELECT_I,
  input  wire logic       DOUBLE_SPEED_I,
  input  wire logic [1:0] MODE_I,
  input  wire logic       BIT_ORDER_SELECT_I,
  input  wire logic       BUFFERED_ENABLE_I,
  input  wire logic       WAIT_FOR_RECEIVE_I,
  input  wire logic       SELECT_PIN_DISABLE_I,
  input  wire logic       TRANSFER_DONE_IRQ_EN_I,
  input  wire logic       TX_COMPLETE_IRQ_EN_I,
  input  wire logic       DATA_WR_I,
  input  wire logic [7:0] DATA_WDATA_I,
  input  wire logic       DATA_RD_I,
  output logic      [7:0] DATA_RDATA_O,
  input  wire logic       DONE_CLR_I,
  input  wire logic       COLLISION_CLR_I,
  input  wire logic       COMPLETE_CLR_I,
  output logic            TRANSFER_DONE_FLAG_O,
  output logic            WRITE_COLLISION_FLAG_O,
  output logic            TX_EMPTY_FLAG_O,
  output logic            TX_COMPLETE_FLAG_O,
  output logic            IRQ_O,
  input  wire logic       MOSI_DIR_I,
  input  wire logic       MISO_DIR_I,
  input  wire logic       SCK_DIR_I,
  input  wire logic       SS_DIR_I,
  input  wire logic       SELECT_LEVEL_I,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE_O,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE_O,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE_O,
  input  wire logic       SS_I,
  output logic            SS_O,
  output logic            SS_OE_O
);
  logic [smsc_pkg::SMSC_PIN_N-1:0] pin_s;
  smsc_pkg::smsc_state_t state_r, state_nxt;
  logic [7:0] sreg_r, sreg_nxt, txbuf_r, rx1_r, rx2_r;
  logic [3:0] cnt_r, cnt_nxt;
  logic [6:0] div_r, div_nxt;
  logic [1:0] rx_cnt_r;
  logic       out_r, out_nxt, sck_r, sck_nxt, sck_d_r, master_r, tx_empty_r;
  logic       done_r, write_collision_flag_r, txc_r;

  smsc_sync #(.WIDTH(smsc_pkg::SMSC_PIN_N)) u_sync (
    .clk_i (MCLK_I),
    .rst_i (SRST_I),
    .d_i   ({SS_I, SCK_I, MISO_I, MOSI_I}),
    .q_o   (pin_s)
  );

  wire mosi_s = pin_s[smsc_pkg::SMSC_PIN_MOSI];
  wire miso_s = pin_s[smsc_pkg::SMSC_PIN_MISO];
  wire sck_s  = pin_s[smsc_pkg::SMSC_PIN_SCK];
  wire ss_s   = pin_s[smsc_pkg::SMSC_PIN_SS];
  wire cpol   = MODE_I[1];
  wire cpha   = MODE_I[0];
  wire lsb    = BIT_ORDER_SELECT_I;
  wire buffered_enable  = BUFFERED_ENABLE_I;
  wire is_m   = ENABLE_I & master_r;
  wire is_s   = ENABLE_I & ~master_r;
  wire busy   = (state_r == smsc_pkg::SMSC_ST_SHIFT);
  wire xbusy  = busy | (is_s & (cnt_r != smsc_pkg::SMSC_CNT_ZERO));

  // Master clock generator, half period from divider and double speed
  wire [6:0] half = smsc_pkg::SMSC_HALF_TAB[CLOCK_DIVIDER_SELECT_I] >> DOUBLE_SPEED_I;
  wire tick    = busy & is_m & (div_r == half - smsc_pkg::SMSC_DIV_ONE);
  wire m_lead  = tick & (sck_r == cpol);
  wire m_trail = tick & (sck_r != cpol);
  // Slave edges come from the synchronised clock, never the pin itself
  wire s_act   = is_s & ~ss_s;
  wire s_lead  = s_act & (sck_s != cpol) & (sck_d_r == cpol);
  wire s_trail = s_act & (sck_s == cpol) & (sck_d_r != cpol);
  wire lead    = m_lead | s_lead;
  wire trail   = m_trail | s_trail;
  wire samp_ev = cpha ? trail : lead;
  wire shft_ev = cpha ? lead : trail;
  wire in_bit  = is_m ? miso_s : mosi_s;
  wire [7:0] sreg_in = lsb ? {in_bit, sreg_r[7:1]} : {sreg_r[6:0], in_bit};
  wire next_out = lsb ? sreg_r[0] : sreg_r[7];
  wire [3:0] m_end = cpha ? smsc_pkg::SMSC_CNT_LAST : smsc_pkg::SMSC_CNT_BYTE;
  wire m_done  = m_trail & (cnt_r == m_end);
  wire s_done  = s_act & samp_ev & (cnt_r == smsc_pkg::SMSC_CNT_LAST);
  wire x_done  = m_done | s_done;
  wire [7:0] rx_byte = samp_ev ? sreg_in : sreg_r;

  // Data register write paths
  wire wr_now  = DATA_WR_I & ~buffered_enable & ~xbusy;
  wire wr_col  = DATA_WR_I & ~buffered_enable & xbusy;
  wire wr_dir  = DATA_WR_I & buffered_enable & tx_empty_r & is_m & ~busy;
  wire wr_buf  = DATA_WR_I & buffered_enable & tx_empty_r & ~wr_dir;
  wire reload  = x_done & buffered_enable & ~tx_empty_r;
  // Wait-for-receive matters only to a slave preloading while deselected
  wire s_pre   = buffered_enable & WAIT_FOR_RECEIVE_I & is_s & ss_s & ~tx_empty_r;
  wire from_tx = reload | s_pre;
  wire load    = wr_now | (wr_col & is_m) | wr_dir | from_tx;
  wire start   = is_m & (wr_now | wr_dir | reload);
  wire [7:0] ld_data = from_tx ? txbuf_r : DATA_WDATA_I;
  wire ld_bit  = lsb ? ld_data[0] : ld_data[7];
  // Another master pulling select low takes the bus from us
  wire mm_sw   = is_m & ~SELECT_PIN_DISABLE_I & ~SS_DIR_I & ~ss_s;
  wire rx_pop  = DATA_RD_I & buffered_enable & (rx_cnt_r != smsc_pkg::SMSC_RX_EMPTY);
  wire rx_push = x_done & buffered_enable;

  always_comb begin
    sreg_nxt  = sreg_r;
    out_nxt   = out_r;
    cnt_nxt   = cnt_r;
    state_nxt = state_r;
    sck_nxt   = sck_r;
    div_nxt   = div_r;
    if (busy) begin
      div_nxt = tick ? smsc_pkg::SMSC_DIV_ZERO : div_r + smsc_pkg::SMSC_DIV_ONE;
      if (tick) begin
        sck_nxt = ~sck_r;
      end
    end else begin
      sck_nxt = cpol;
    end
    if (samp_ev) begin
      sreg_nxt = sreg_in;
      cnt_nxt  = cnt_r + 4'h1;
    end
    if (shft_ev) begin
      out_nxt = next_out;
    end
    if (x_done) begin
      cnt_nxt   = smsc_pkg::SMSC_CNT_ZERO;
      state_nxt = smsc_pkg::SMSC_ST_IDLE;
      sck_nxt   = cpol;
      div_nxt   = smsc_pkg::SMSC_DIV_ZERO;
    end
    if (is_s & ss_s) begin
      cnt_nxt = smsc_pkg::SMSC_CNT_ZERO;
      out_nxt = next_out;
    end
    if (load) begin
      sreg_nxt = ld_data;
      out_nxt  = ld_bit;
    end
    if (start) begin
      state_nxt = smsc_pkg::SMSC_ST_SHIFT;
      cnt_nxt   = smsc_pkg::SMSC_CNT_ZERO;
      sck_nxt   = cpol;
      div_nxt   = smsc_pkg::SMSC_DIV_ZERO;
    end
    // A core that stops being master abandons its byte
    if (~is_m | mm_sw) begin
      state_nxt = smsc_pkg::SMSC_ST_IDLE;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state_r <= smsc_pkg::SMSC_ST_IDLE;
      sreg_r  <= smsc_pkg::SMSC_BYTE_RST;
      out_r   <= 1'b0;
      cnt_r   <= smsc_pkg::SMSC_CNT_ZERO;
      sck_r   <= 1'b0;
      div_r   <= smsc_pkg::SMSC_DIV_ZERO;
      sck_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sreg_r  <= sreg_nxt;
      out_r   <= out_nxt;
      cnt_r   <= cnt_nxt;
      sck_r   <= sck_nxt;
      div_r   <= div_nxt;
      sck_d_r <= sck_s;
    end
  end

  // Master bit, flags and transmit buffer; a hardware set beats a clear
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      master_r   <= smsc_pkg::SMSC_MASTER_RST;
      done_r     <= 1'b0;
      write_collision_flag_r    <= 1'b0;
      txc_r      <= 1'b0;
      tx_empty_r <= 1'b1;
      txbuf_r    <= smsc_pkg::SMSC_BYTE_RST;
    end else begin
      if (mm_sw) begin
        master_r <= 1'b0;
      end else if (MASTER_WR_I) begin
        master_r <= MASTER_WDATA_I;
      end
      done_r  <= (done_r & ~DONE_CLR_I) | x_done | mm_sw;
      write_collision_flag_r <= (write_collision_flag_r & ~COLLISION_CLR_I) | wr_col;
      txc_r   <= (txc_r & ~COMPLETE_CLR_I) | (x_done & buffered_enable & tx_empty_r);
      if (wr_buf) begin
        txbuf_r    <= DATA_WDATA_I;
        tx_empty_r <= 1'b0;
      end else if (from_tx) begin
        tx_empty_r <= 1'b1;
      end
    end
  end

  // Receive side: one buffer unbuffered, a two-entry queue buffered
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rx1_r    <= smsc_pkg::SMSC_BYTE_RST;
      rx2_r    <= smsc_pkg::SMSC_BYTE_RST;
      rx_cnt_r <= smsc_pkg::SMSC_RX_EMPTY;
    end else if (~buffered_enable) begin
      rx_cnt_r <= smsc_pkg::SMSC_RX_EMPTY;
      if (x_done) begin
        rx1_r <= rx_byte;
      end
    end else if (rx_push & rx_pop) begin
      if (rx_cnt_r == smsc_pkg::SMSC_RX_ONE) begin
        rx2_r <= rx_byte;
      end else begin
        rx2_r <= rx1_r;
        rx1_r <= rx_byte;
      end
    end else if (rx_push) begin
      // A third byte overwrites the newest entry: software read too late
      if (rx_cnt_r == smsc_pkg::SMSC_RX_EMPTY) begin
        rx2_r    <= rx_byte;
        rx_cnt_r <= smsc_pkg::SMSC_RX_ONE;
      end else begin
        rx1_r    <= rx_byte;
        rx_cnt_r <= smsc_pkg::SMSC_RX_FULL;
      end
    end else if (rx_pop) begin
      rx2_r    <= rx1_r;
      rx_cnt_r <= rx_cnt_r - smsc_pkg::SMSC_RX_ONE;
    end
  end

  // Pin directions: enabled core forces its input pins, else the port decides
  wire mosi_oe = is_s ? 1'b0 : MOSI_DIR_I;
  wire sck_oe  = is_s ? 1'b0 : SCK_DIR_I;
  wire ss_oe   = is_s ? 1'b0 : SS_DIR_I;
  wire miso_oe = is_m ? 1'b0 : (is_s ? (MISO_DIR_I & ~ss_s) : MISO_DIR_I);
  wire irq     = (done_r & TRANSFER_DONE_IRQ_EN_I) | (txc_r & TX_COMPLETE_IRQ_EN_I);

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      MOSI_O <= 1'b0;
      MOSI_OE_O <= 1'b0;
      MISO_O <= 1'b0;
      MISO_OE_O <= 1'b0;
      SCK_O <= 1'b0;
      SCK_OE_O <= 1'b0;
      SS_O <= 1'b1;
      SS_OE_O <= 1'b0;
      DATA_RDATA_O <= smsc_pkg::SMSC_BYTE_RST;
      IRQ_O <= 1'b0;
    end else begin
      MOSI_O <= out_r;
      MOSI_OE_O <= mosi_oe;
      MISO_O <= out_r;
      MISO_OE_O <= miso_oe;
      SCK_O <= busy ? sck_r : cpol;
      SCK_OE_O <= sck_oe;
      SS_O <= SELECT_LEVEL_I;
      SS_OE_O <= ss_oe;
      DATA_RDATA_O <= buffered_enable ? rx2_r : rx1_r;
      IRQ_O <= irq;
    end
  end

  assign MASTER_O = master_r;
  assign TRANSFER_DONE_FLAG_O = done_r;
  assign WRITE_COLLISION_FLAG_O = write_collision_flag_r;
  assign TX_EMPTY_FLAG_O = tx_empty_r;
  assign TX_COMPLETE_FLAG_O = txc_r;

  // Checks
  sequence s_quiet;
    !x_done [*8] ##1 !x_done [*7];
  endsequence
  property p_len;
    @(posedge MCLK_I) disable iff (SRST_I) $rose(busy) |-> s_quiet;
  endproperty
  a_len: assert property (p_len) else $error("byte ended early");
  property p_switch;
    @(posedge MCLK_I) disable iff (SRST_I) mm_sw |=> !master_r && done_r && !busy;
  endproperty
  a_switch: assert property (p_switch) else $error("no drop to slave");
  property p_ssd;
    @(posedge MCLK_I) disable iff (SRST_I)
      is_m && (SELECT_PIN_DISABLE_I || SS_DIR_I) && !MASTER_WR_I |=> master_r;
  endproperty
  a_ssd: assert property (p_ssd) else $error("select pin acted");
  property p_miso;
    @(posedge MCLK_I) disable iff (SRST_I) is_s && ss_s |=> !MISO_OE_O;
  endproperty
  a_miso: assert property (p_miso) else $error("MISO driven deselected");
  property p_slave_pins;
    @(posedge MCLK_I) disable iff (SRST_I) is_s |=> !MOSI_OE_O && !SCK_OE_O && !SS_OE_O;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave pin driven");
  property p_write_collision_flag;
    @(posedge MCLK_I) disable iff (SRST_I) DATA_WR_I && !buffered_enable && xbusy |=> write_collision_flag_r;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed");
  property p_start;
    @(posedge MCLK_I) disable iff (SRST_I)
      is_m && !buffered_enable && !busy && DATA_WR_I |=> busy ##0 sreg_r == $past(DATA_WDATA_I);
  endproperty
  a_start: assert property (p_start) else $error("write did not start");
  property p_rx1;
    @(posedge MCLK_I) disable iff (SRST_I) x_done && !buffered_enable |=> rx1_r == $past(rx_byte) && done_r;
  endproperty
  a_rx1: assert property (p_rx1) else $error("byte not captured");
  property p_txc;
    @(posedge MCLK_I) disable iff (SRST_I) x_done && buffered_enable && tx_empty_r |=> txc_r;
  endproperty
  a_txc: assert property (p_txc) else $error("complete flag missed");
  property p_ss_reset;
    @(posedge MCLK_I) disable iff (SRST_I) is_s && ss_s && !is_m |=> cnt_r == smsc_pkg::SMSC_CNT_ZERO;
  endproperty
  a_ss_reset: assert property (p_ss_reset) else $error("slave count kept");
  property p_fifo;
    @(posedge MCLK_I) disable iff (SRST_I)
      rx_push && !rx_pop && rx_cnt_r == smsc_pkg::SMSC_RX_EMPTY |=>
      rx_cnt_r == smsc_pkg::SMSC_RX_ONE && rx2_r == $past(rx_byte);
  endproperty
  a_fifo: assert property (p_fifo) else $error("queue push wrong");
endmodule // smsc_core

// ===== hdl/smsc_sync.sv
// Two-stage synchroniser bank for the serial pins
`timescale 1ns/1ns
module smsc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second; nothing else may look at it
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_r[g] <= 1'b0;
        q_o[g]    <= 1'b0;
      end else begin
        meta_r[g] <= d_i[g];
        q_o[g]    <= meta_r[g];
      end
    end
  end
endmodule // smsc_sync

// ===== verification/smsc_core_tb.sv
// Self-checking bench for the serial peripheral interface core
`timescale 1ns/1ns
module smsc_core_tb;
  logic        clk = 1'b0;
  logic        dclr = 1'b0;
  logic        auto_clr = 1'b1;
  logic        fd_q = 1'b0;
  logic        rst, ena, mwd, bo, buf_en, wfr, sdis, dne, cen, dwr, sel_lvl;
  logic        mosi_dir, miso_dir, sck_dir, ss_dir, tb_ss, tb_sck, tb_mosi;
  logic  [3:0] stb;
  logic  [1:0] mode;
  logic  [7:0] wd, ptx, cap, p_rx, p_cnt, rdata;
  logic        master, fdone, fcol, fempty, fcomp, irq, p_miso;
  logic        mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_o, ss_oe;
  logic  [7:0] rd_q[$];
  logic  [7:0] far_q[$];
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 32'he5b6_fb0b;
  wire         sck_w  = sck_oe ? sck_o : tb_sck;
  wire         ss_w   = ss_oe ? ss_o : tb_ss;
  wire         mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire         miso_w = miso_oe ? miso_o : p_miso;

  // Divider 1 with double speed gives an 800 ns serial clock
  smsc_core DUT (
    .MCLK_I(clk), .SRST_I(rst), .ENABLE_I(ena), .MASTER_WR_I(stb[0]), .MASTER_WDATA_I(mwd),
    .MASTER_O(master), .CLOCK_DIVIDER_SELECT_I(2'h1), .DOUBLE_SPEED_I(1'b1), .MODE_I(mode),
    .BIT_ORDER_SELECT_I(bo), .BUFFERED_ENABLE_I(buf_en), .WAIT_FOR_RECEIVE_I(wfr),
    .SELECT_PIN_DISABLE_I(sdis), .TRANSFER_DONE_IRQ_EN_I(dne), .TX_COMPLETE_IRQ_EN_I(cen),
    .DATA_WR_I(dwr), .DATA_WDATA_I(wd), .DATA_RD_I(stb[1]), .DATA_RDATA_O(rdata),
    .DONE_CLR_I(dclr), .COLLISION_CLR_I(stb[2]), .COMPLETE_CLR_I(stb[3]),
    .TRANSFER_DONE_FLAG_O(fdone), .WRITE_COLLISION_FLAG_O(fcol), .TX_EMPTY_FLAG_O(fempty),
    .TX_COMPLETE_FLAG_O(fcomp), .IRQ_O(irq), .MOSI_DIR_I(mosi_dir), .MISO_DIR_I(miso_dir),
    .SCK_DIR_I(sck_dir), .SS_DIR_I(ss_dir), .SELECT_LEVEL_I(sel_lvl), .MOSI_I(mosi_w),
    .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE_O(miso_oe), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .SS_I(ss_w),
    .SS_O(ss_o), .SS_OE_O(ss_oe));

  smsc_far_slave u_far (.sck_i(sck_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .mode_i(mode),
    .tx_i(ptx), .miso_o(p_miso), .rx_o(p_rx), .cnt_o(p_cnt));

  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] d);
    dwr <= 1'b1;
    wd <= d;
    @(posedge clk);
    dwr <= 1'b0;
  endtask

  task automatic strobe(input int i);
    stb[i] <= 1'b1;
    @(posedge clk);
    stb <= 4'h0;
  endtask

  task automatic wflag(input int sel);
    int k;
    k = 0;
    while ((sel ? fcomp : fdone) !== 1'b1 && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (k == 600) chk("flag wait", 8'h00, 8'h01);
  endtask

  // Odd offset keeps the link clock unrelated to the core clock
  task automatic frame(input logic [7:0] v, input int n);
    #137;
    for (int i = 7; i > 7 - n; i--) begin
      tb_mosi = v[i];
      #400 tb_sck = 1'b1;
      #350 cap = {cap[6:0], miso_w};
      #50 tb_sck = 1'b0;
    end
    #400;
  endtask

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction

  // Done flag is cleared once seen, so each completion shows as a new rise
  always @(posedge clk) dclr <= auto_clr & fdone & ~dclr;

  always @(posedge clk) begin
    fd_q <= fdone;
    if (fdone === 1'b1 && fd_q !== 1'b1 && rd_q.size() > 0) begin
      repeat (2) @(posedge clk);
      chk("read data", rdata, rd_q.pop_front());
      if (far_q.size() > 0) chk("far byte", p_rx, far_q.pop_front());
    end
  end

  initial begin
    logic [7:0] a, b, c, d, e;
    {ena, mwd, bo, buf_en, wfr, sdis, dne, cen, dwr, stb, mode, wd, ptx} = '0;
    {mosi_dir, miso_dir, sck_dir, ss_dir, tb_sck, tb_mosi, cap} = '0;
    {rst, sel_lvl, tb_ss} = 3'h7;
    wt(8);
    rst <= 1'b0;
    wt(3);
    chk("reset state", {fdone, fcol, fempty, fcomp, irq, master, ss_o, sck_oe}, 8'h22);
    chk("read data", rdata, 8'h00);
    {ss_dir, mosi_dir, sck_dir, miso_dir, mwd, dne, cen} <= 7'h7f;
    strobe(0);
    ena <= 1'b1;
    wt(3);
    chk("master pins", 8'({master, miso_oe, mosi_oe, sck_oe, ss_oe}), 8'h17);
    for (int m = 0; m < 8; m++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      {bo, mode} <= 3'(m);
      ptx <= a;
      wt(4);
      sel_lvl <= 1'b0;
      wt(3);
      rd_q.push_back(m[2] ? rev(a) : a);
      far_q.push_back(m[2] ? rev(b) : b);
      wr(b);
      wflag(0);
      wt(4);
      sel_lvl <= 1'b1;
    end
    chk("master bit", 8'(master), 8'h01);
    {bo, mode} <= 3'h0;
    sel_lvl <= 1'b0;
    wt(4);
    wr(8'ha5);
    wt(10);
    wr(8'h5a);
    wflag(0);
    wt(4);
    chk("collision", 8'(fcol), 8'h01);
    strobe(2);
    wt(2);
    chk("collision", 8'(fcol), 8'h00);
    sel_lvl <= 1'b1;
    strobe(3);
    a = 8'($random(seed));
    b = 8'($random(seed));
    c = 8'($random(seed));
    d = 8'($random(seed));
    {buf_en, wfr} <= 2'h3;
    ptx <= a;
    wt(3);
    sel_lvl <= 1'b0;
    wt(3);
    ptx <= b;
    e = p_cnt;
    rd_q.push_back(a);
    rd_q.push_back(a);
    far_q.push_back(c);
    far_q.push_back(d);
    dwr <= 1'b1;
    wd <= c;
    @(posedge clk);
    wd <= d;
    @(posedge clk);
    dwr <= 1'b0;
    wt(2);
    chk("tx empty", 8'(fempty), 8'h00);
    wr(~d);
    wflag(1);
    wt(80);
    chk("byte count", p_cnt - e, 8'h02);
    chk("complete irq", 8'({fcomp, irq}), 8'h03);
    strobe(1);
    wt(3);
    chk("read data", rdata, b);
    strobe(3);
    sel_lvl <= 1'b1;
    buf_en <= 1'b0;
    auto_clr <= 1'b0;
    {sdis, ss_dir} <= 2'h2;
    tb_ss <= 1'b0;
    wt(10);
    chk("master bit", 8'(master), 8'h01);
    sdis <= 1'b0;
    wt(6);
    chk("takeover", 8'({master, fdone, irq, mosi_oe, sck_oe, ss_oe}), 8'h18);
    auto_clr <= 1'b1;
    tb_ss <= 1'b1;
    wt(5);
    chk("miso enable", 8'(miso_oe), 8'h00);
    tb_ss <= 1'b0;
    wt(5);
    chk("miso enable", 8'(miso_oe), 8'h01);
    frame(8'hff, 3);
    wt(1);
    tb_ss <= 1'b1;
    wt(4);
    a = 8'($random(seed));
    b = 8'($random(seed));
    wr(a);
    wt(2);
    tb_ss <= 1'b0;
    rd_q.push_back(b);
    wt(2);
    frame(b, 8);
    chk("slave out", cap, a);
    wt(1);
    tb_ss <= 1'b1;
    wt(8);
    strobe(0);
    wt(2);
    chk("master bit", 8'(master), 8'h01);
    test_done();
  end

  initial begin
    #2000000;
    error_cnt++;
    $display("[FAIL] watchdog expired");
    test_done();
  end
endmodule // smsc_core_tb

// ===== verification/smsc_far_slave.sv
// Behavioural far-side slave that answers the core in master mode
`timescale 1ns/1ns
module smsc_far_slave (
  input  wire logic       sck_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o,
  output logic      [7:0] cnt_o
);
  logic [7:0] tx_r   = 8'h00;
  logic [7:0] sh_r   = 8'h00;
  logic [7:0] rx_r   = 8'h00;
  logic [7:0] cnt_r  = 8'h00;
  logic       miso_r = 1'b0;
  logic       ss_q   = 1'b1;
  int         n_out  = 0;
  int         n_in   = 0;

  assign miso_o = miso_r;
  assign rx_o   = rx_r;
  assign cnt_o  = cnt_r;

  // One process owns every variable, so frame and clock edges never race
  always @(ss_n_i or sck_i) begin
    if (ss_n_i === 1'b0 && ss_q !== 1'b0) begin
      // Frame start shows the first bit at once for phase 0
      tx_r   = tx_i;
      n_in   = 0;
      n_out  = mode_i[0] ? 0 : 1;
      miso_r = tx_i[7];
    end else if (ss_n_i === 1'b1 && ss_q === 1'b0) begin
      // Released line flips so a stale bit never passes for data
      miso_r = ~miso_r;
    end else if (ss_n_i === 1'b0) begin
      if ((sck_i !== mode_i[1]) ^ mode_i[0]) begin
        sh_r = {sh_r[6:0], mosi_i};
        n_in++;
        if (n_in % 8 == 0) begin
          rx_r  = sh_r;
          cnt_r = cnt_r + 8'h01;
        end
      end else begin
        // Next byte is fetched only at the byte boundary
        if (n_out == 8) begin
          tx_r  = tx_i;
          n_out = 0;
        end
        miso_r = tx_r[7 - n_out];
        n_out++;
      end
    end
    ss_q = ss_n_i;
  end
endmodule // smsc_far_slave
